// ---- hdl/ucm_port_ctl.sv ----
`include "ucm_cfg.svh"

// Overview of operation
// - auxiliary output b pin is the inverse of control bit 13
// - auxiliary output a pin is the inverse of control bit 12
// - request-to-send pin is the inverse of control bit 11
// - terminal-ready pin is the inverse of control bit 10
// - control bit 9 enables the receive section, zero disables it
// - receiver takes normal or infrared input as infrared enable bit 1 selects
// - receive disabled mid character still finishes that character
// - control bit 8 enables the transmit section, zero disables it
// - transmitter sends on normal or infrared output per infrared enable bit 1
// - transmit disabled mid character still finishes that whole character
// - loopback, infrared enable and infrared test set: inverted infrared output feeds input
// - loopback with infrared test clear feeds serial transmit into serial receive
// - loopback in any mode also feeds modem outputs into modem inputs
// - reset clears the loopback bit
// - transmit or receive needs its own enable and global port enable bit 0
// - infrared mode holds serial output high, ignores serial and modem inputs

module ucm_port_ctl (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic [`UCM_ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [15:0]             o_rdata,
  input  wire logic                    i_serial_receive_pin,
  output logic                         o_serial_transmit_pin,
  input  wire logic                    i_infrared_input,
  output logic                         o_infrared_output_n,
  input  wire logic                    i_clear_send_pin_n,
  input  wire logic                    i_set_ready_pin_n,
  input  wire logic                    i_carrier_pin_n,
  input  wire logic                    i_ring_pin_n,
  output logic                         o_request_send_pin_n,
  output logic                         o_terminal_ready_pin_n,
  output logic                         o_aux_modem_output_a_pin_n,
  output logic                         o_aux_modem_output_b_pin_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0]          ctrl_ff;
  logic [15:0]          test_ff;
  logic [15:0]          rdata_ff;
  logic [3:0]           mdm_n_ff;
  logic                 txd_ff;
  logic [4:0]           div_ff;
  logic                 tick;
  logic [5:0]           pin_sync;
  logic                 rxd_sync;
  logic                 ir_sync;
  logic [3:0]           mdm_in_n;
  logic                 ir_pulse;

  ucm_pkg::ucm_state_t  tx_state_ff;
  ucm_pkg::ucm_state_t  nxt_tx_state;
  logic [3:0]           tx_tick_ff;
  logic [3:0]           nxt_tx_tick;
  logic [2:0]           tx_cnt_ff;
  logic [2:0]           nxt_tx_cnt;
  logic [7:0]           tx_shift_ff;
  logic [7:0]           nxt_tx_shift;
  logic                 tx_bit_ff;
  logic                 nxt_tx_bit;
  logic [7:0]           tx_hold_ff;
  logic                 tx_full_ff;

  ucm_pkg::ucm_state_t  rx_state_ff;
  ucm_pkg::ucm_state_t  nxt_rx_state;
  logic [3:0]           rx_tick_ff;
  logic [3:0]           nxt_rx_tick;
  logic [2:0]           rx_cnt_ff;
  logic [2:0]           nxt_rx_cnt;
  logic [7:0]           rx_shift_ff;
  logic [7:0]           nxt_rx_shift;
  logic [7:0]           rx_data_ff;
  logic                 rx_valid_ff;
  logic                 frame_err_ff;
  logic                 rx_done;
  logic [3:0]           ir_hold_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hit(input logic [`UCM_ADDR_W-1:0] a,
                               input logic [`UCM_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  wire wr_ctrl = i_wr & hit(i_addr, `UCM_CTRL_OFF);
  wire wr_test = i_wr & hit(i_addr, `UCM_TEST_OFF);
  wire wr_data = i_wr & hit(i_addr, `UCM_DATA_OFF);
  wire rd_data = i_rd & hit(i_addr, `UCM_DATA_OFF);

  // next control value, reserved bits forced to zero
  wire [15:0] nxt_ctrl = wr_ctrl ? (i_wdata & `UCM_CR_RW_MASK) : ctrl_ff;

  // control field views
  wire port_ena = ctrl_ff[`UCM_CR_PORT_ENA];
  wire ir_ena   = ctrl_ff[`UCM_CR_IR_ENA];
  wire loop_ena = ctrl_ff[`UCM_CR_LOOP];
  wire ir_test  = test_ff[`UCM_TCR_IR_TEST];
  wire tx_go    = port_ena & ctrl_ff[`UCM_CR_TX_ENA];
  wire rx_go    = port_ena & ctrl_ff[`UCM_CR_RX_ENA];

  ////////////////////////////////////////////////////////////////////////////////
  // control and test registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff <= `UCM_CR_RST;
      test_ff <= `UCM_TCR_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_test) begin
        test_ff <= i_wdata & `UCM_TCR_RW_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modem output pins, inverse of the programmed bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mdm_n_ff <= 4'hf;
    end else begin
      mdm_n_ff[3] <= ~nxt_ctrl[`UCM_CR_AUX_B];
      mdm_n_ff[2] <= ~nxt_ctrl[`UCM_CR_AUX_A];
      mdm_n_ff[1] <= ~nxt_ctrl[`UCM_CR_REQ_SEND];
      mdm_n_ff[0] <= ~nxt_ctrl[`UCM_CR_TERM_RDY];
    end
  end

  assign o_aux_modem_output_b_pin_n = mdm_n_ff[3];
  assign o_aux_modem_output_a_pin_n = mdm_n_ff[2];
  assign o_request_send_pin_n       = mdm_n_ff[1];
  assign o_terminal_ready_pin_n     = mdm_n_ff[0];

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: rxd, infrared, clear-send, set-ready, carrier, ring
  ucm_sync2 #(
    .W    (6),
    .RST  (6'h3f)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_ring_pin_n, i_carrier_pin_n, i_set_ready_pin_n,
               i_clear_send_pin_n, i_serial_receive_pin, i_infrared_input}),
    .o_q     (pin_sync)
  );

  assign ir_sync  = pin_sync[0];
  assign rxd_sync = pin_sync[1];
  assign mdm_in_n = pin_sync[5:2];

  ////////////////////////////////////////////////////////////////////////////////
  // modem inputs seen by software, active high
  wire [3:0] mdm_loop = {ctrl_ff[`UCM_CR_AUX_B], ctrl_ff[`UCM_CR_AUX_A],
                         ctrl_ff[`UCM_CR_TERM_RDY], ctrl_ff[`UCM_CR_REQ_SEND]};
  wire [3:0] mdm_seen = loop_ena ? mdm_loop :
                        ir_ena   ? 4'h0     :
                        ~mdm_in_n;

  ////////////////////////////////////////////////////////////////////////////////
  // 16x oversampling tick
  assign tick = (div_ff == `UCM_TICK_LAST);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= 5'h00;
    end else begin
      div_ff <= tick ? 5'h00 : div_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit engine, 8 data bits, one stop bit
  wire tx_adv = tick & (tx_tick_ff == `UCM_LAST_TICK);

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_tick  = tx_tick_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_bit   = tx_bit_ff;
    if (tick && tx_state_ff != ucm_pkg::UCM_IDLE) begin
      nxt_tx_tick = tx_tick_ff + 4'h1;
    end
    case (tx_state_ff)
      ucm_pkg::UCM_IDLE: begin
        nxt_tx_bit = 1'b1;
        if (tx_go && tx_full_ff) begin
          nxt_tx_state = ucm_pkg::UCM_START;
          nxt_tx_shift = tx_hold_ff;
          nxt_tx_tick  = 4'h0;
          nxt_tx_bit   = 1'b0;
        end
      end
      ucm_pkg::UCM_START: begin
        if (tx_adv) begin
          nxt_tx_state = ucm_pkg::UCM_DATA;
          nxt_tx_cnt   = 3'h0;
          nxt_tx_bit   = tx_shift_ff[0];
        end
      end
      ucm_pkg::UCM_DATA: begin
        // enable is not looked at here, the character always finishes
        if (tx_adv) begin
          nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
          nxt_tx_cnt   = tx_cnt_ff + 3'h1;
          nxt_tx_bit   = tx_shift_ff[1];
          if (tx_cnt_ff == `UCM_LAST_BIT) begin
            nxt_tx_state = ucm_pkg::UCM_STOP;
            nxt_tx_bit   = 1'b1;
          end
        end
      end
      ucm_pkg::UCM_STOP: begin
        if (tx_adv) begin
          nxt_tx_state = ucm_pkg::UCM_IDLE;
        end
      end
      default: begin
        nxt_tx_state = ucm_pkg::UCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state_ff <= ucm_pkg::UCM_IDLE;
      tx_tick_ff  <= 4'h0;
      tx_cnt_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_bit_ff   <= 1'b1;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_tick_ff  <= nxt_tx_tick;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_shift_ff <= nxt_tx_shift;
      tx_bit_ff   <= nxt_tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit holding register, one character
  wire tx_load = (tx_state_ff == ucm_pkg::UCM_IDLE) & tx_go & tx_full_ff;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_hold_ff <= 8'h00;
      tx_full_ff <= 1'b0;
    end else if (wr_data && !tx_full_ff) begin
      tx_hold_ff <= i_wdata[7:0];
      tx_full_ff <= 1'b1;
    end else if (tx_load) begin
      tx_full_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial output pin, marking while infrared is on
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txd_ff <= 1'b1;
    end else begin
      txd_ff <= ir_ena ? 1'b1 : nxt_tx_bit;
    end
  end

  assign o_serial_transmit_pin = txd_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // infrared encoder, pulse only while port and infrared are enabled
  ucm_ir_enc u_ir_enc (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ena   (port_ena & ir_ena),
    .i_bit   (tx_bit_ff),
    .i_phase (tx_tick_ff),
    .o_pulse (ir_pulse)
  );

  assign o_infrared_output_n = ir_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // receive path selection and loopback
  wire ir_in  = (loop_ena & ir_ena & ir_test) ? ~ir_pulse : ir_sync;
  wire ser_in = (loop_ena & ~ir_test) ? tx_bit_ff : rxd_sync;

  // infrared decoder: a low pulse holds a zero bit for one bit period
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_hold_ff <= 4'h0;
    end else if (!ir_in) begin
      ir_hold_ff <= `UCM_LAST_TICK;
    end else if (tick && ir_hold_ff != 4'h0) begin
      ir_hold_ff <= ir_hold_ff - 4'h1;
    end
  end

  wire ir_bit = (ir_hold_ff == 4'h0) & ir_in;
  wire rx_in  = ir_ena ? ir_bit : ser_in;

  ////////////////////////////////////////////////////////////////////////////////
  // receive engine
  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_tick  = rx_tick_ff;
    nxt_rx_cnt   = rx_cnt_ff;
    nxt_rx_shift = rx_shift_ff;
    rx_done      = 1'b0;
    if (tick && rx_state_ff != ucm_pkg::UCM_IDLE) begin
      nxt_rx_tick = rx_tick_ff + 4'h1;
    end
    case (rx_state_ff)
      ucm_pkg::UCM_IDLE: begin
        if (rx_go && !rx_in) begin
          nxt_rx_state = ucm_pkg::UCM_START;
          nxt_rx_tick  = 4'h0;
        end
      end
      ucm_pkg::UCM_START: begin
        if (tick && rx_tick_ff == `UCM_MID_TICK) begin
          nxt_rx_tick  = 4'h0;
          nxt_rx_cnt   = 3'h0;
          nxt_rx_state = rx_in ? ucm_pkg::UCM_IDLE : ucm_pkg::UCM_DATA;
        end
      end
      ucm_pkg::UCM_DATA: begin
        // runs to the stop bit even if reception is switched off
        if (tick && rx_tick_ff == `UCM_LAST_TICK) begin
          nxt_rx_shift = {rx_in, rx_shift_ff[7:1]};
          nxt_rx_cnt   = rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == `UCM_LAST_BIT) begin
            nxt_rx_state = ucm_pkg::UCM_STOP;
          end
        end
      end
      ucm_pkg::UCM_STOP: begin
        if (tick && rx_tick_ff == `UCM_LAST_TICK) begin
          nxt_rx_state = ucm_pkg::UCM_IDLE;
          rx_done      = 1'b1;
        end
      end
      default: begin
        nxt_rx_state = ucm_pkg::UCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state_ff <= ucm_pkg::UCM_IDLE;
      rx_tick_ff  <= 4'h0;
      rx_cnt_ff   <= 3'h0;
      rx_shift_ff <= 8'h00;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_tick_ff  <= nxt_rx_tick;
      rx_cnt_ff   <= nxt_rx_cnt;
      rx_shift_ff <= nxt_rx_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // received character and flags, a new character wins over a read clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_data_ff   <= 8'h00;
      rx_valid_ff  <= 1'b0;
      frame_err_ff <= 1'b0;
    end else if (rx_done) begin
      rx_data_ff   <= rx_shift_ff;
      rx_valid_ff  <= 1'b1;
      frame_err_ff <= ~rx_in;
    end else if (rd_data) begin
      rx_valid_ff  <= 1'b0;
      frame_err_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets read zero
  wire [15:0] stat_word = {4'h0, mdm_seen[3], mdm_seen[2], mdm_seen[1], mdm_seen[0],
                           3'h0, frame_err_ff,
                           rx_state_ff != ucm_pkg::UCM_IDLE,
                           rx_valid_ff,
                           tx_state_ff != ucm_pkg::UCM_IDLE,
                           tx_full_ff};
  wire [15:0] rd_mux = hit(i_addr, `UCM_CTRL_OFF) ? ctrl_ff :
                       hit(i_addr, `UCM_TEST_OFF) ? test_ff :
                       hit(i_addr, `UCM_STAT_OFF) ? stat_word :
                       hit(i_addr, `UCM_DATA_OFF) ? {8'h00, rx_data_ff} :
                       16'h0000;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= i_rd ? rd_mux : 16'h0000;
    end
  end

  assign o_rdata = rdata_ff;

endmodule : ucm_port_ctl

// ---- pkg/ucm_cfg.svh ----
`ifndef UCM_CFG_SVH
`define UCM_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register map, byte offsets on the plain register port
`define UCM_ADDR_W        8
`define UCM_DATA_OFF      8'h00
`define UCM_STAT_OFF      8'h18
`define UCM_CTRL_OFF      8'h30
`define UCM_TEST_OFF      8'h80

////////////////////////////////////////////////////////////////////////////////
// port control field positions
`define UCM_CR_FLOW_CS    15
`define UCM_CR_FLOW_RS    14
`define UCM_CR_AUX_B      13
`define UCM_CR_AUX_A      12
`define UCM_CR_REQ_SEND   11
`define UCM_CR_TERM_RDY   10
`define UCM_CR_RX_ENA     9
`define UCM_CR_TX_ENA     8
`define UCM_CR_LOOP       7
`define UCM_CR_IR_LP      2
`define UCM_CR_IR_ENA     1
`define UCM_CR_PORT_ENA   0
`define UCM_CR_RST        16'h0300
`define UCM_CR_RW_MASK    16'hff87

////////////////////////////////////////////////////////////////////////////////
// test control field positions
`define UCM_TCR_IR_TEST   2
`define UCM_TCR_RST       16'h0000
`define UCM_TCR_RW_MASK   16'h0004

////////////////////////////////////////////////////////////////////////////////
// status field positions
`define UCM_ST_TX_FULL    0
`define UCM_ST_TX_BUSY    1
`define UCM_ST_RX_VALID   2
`define UCM_ST_RX_BUSY    3
`define UCM_ST_FRAME_ERR  4
`define UCM_ST_CLR_SEND   8
`define UCM_ST_SET_RDY    9
`define UCM_ST_CARRIER    10
`define UCM_ST_RING       11

////////////////////////////////////////////////////////////////////////////////
// timing
`define UCM_CLK_HZ        40000000
`define UCM_BAUD_HZ       115200
`define UCM_OVS           16
`define UCM_TICK_DIV      (`UCM_CLK_HZ / (`UCM_BAUD_HZ * `UCM_OVS))
`define UCM_TICK_LAST     5'(`UCM_TICK_DIV - 1)
`define UCM_IR_PULSE      4'h3
`define UCM_MID_TICK      4'h7
`define UCM_LAST_TICK     4'hf
`define UCM_LAST_BIT      3'h7

`endif

// ---- pkg/ucm_pkg.sv ----
package ucm_pkg;

  // serial engine states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    UCM_IDLE  = 2'b00,
    UCM_START = 2'b01,
    UCM_DATA  = 2'b11,
    UCM_STOP  = 2'b10
  } ucm_state_t;

endpackage : ucm_pkg

// ---- hdl/ucm_sync2.sv ----
module ucm_sync2 #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  input  wire logic [W-1:0]  i_d,
  output logic      [W-1:0]  o_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // two flops per bit, first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_ff <= RST[g];
          sync_ff <= RST[g];
        end else begin
          meta_ff <= i_d[g];
          sync_ff <= meta_ff;
        end
      end
      assign o_q[g] = sync_ff;
    end
  endgenerate

endmodule : ucm_sync2

// ---- hdl/ucm_ir_enc.sv ----
`include "ucm_cfg.svh"

module ucm_ir_enc (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ena,
  input  wire logic        i_bit,
  input  wire logic [3:0]  i_phase,
  output logic             o_pulse
);

  logic pulse_ff;
  logic nxt_pulse;

  // a zero bit becomes a pulse over the first 3/16 of its period
  assign nxt_pulse = i_ena & ~i_bit & (i_phase < `UCM_IR_PULSE);

  ////////////////////////////////////////////////////////////////////////////////
  // registered pulse, low while disabled
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
    end
  end

  assign o_pulse = pulse_ff;

endmodule : ucm_ir_enc

// ---- tb/ucm_port_ctl_assertions.sv ----
`include "ucm_cfg.svh"

module ucm_port_ctl_assertions (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic [`UCM_ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic [15:0]             o_rdata,
  input  wire logic                    o_serial_transmit_pin,
  input  wire logic                    o_infrared_output_n,
  input  wire logic                    o_request_send_pin_n,
  input  wire logic                    o_terminal_ready_pin_n,
  input  wire logic                    o_aux_modem_output_a_pin_n,
  input  wire logic                    o_aux_modem_output_b_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctl_ff;
  wire         ctl_wr = i_wr && (i_addr == `UCM_CTRL_OFF);
  wire         ctl_rd = i_rd && (i_addr == `UCM_CTRL_OFF);
  wire   [3:0] pins   = {o_aux_modem_output_b_pin_n, o_aux_modem_output_a_pin_n,
                         o_request_send_pin_n, o_terminal_ready_pin_n};
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the control register as software wrote it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_ff <= `UCM_CR_RST;
    end else if (ctl_wr) begin
      ctl_ff <= i_wdata & `UCM_CR_RW_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence ctl_write_s;
    ctl_wr;
  endsequence
  sequence ir_on_s;
    ctl_ff[1] && $past(ctl_ff[1]) && $past(ctl_ff[1], 2);
  endsequence
  sequence ir_off_s;
    !ctl_ff[1] && !$past(ctl_ff[1]) && !$past(ctl_ff[1], 2);
  endsequence
  aux_b_pin_a: assert property (
    ctl_write_s |=> o_aux_modem_output_b_pin_n == !$past(i_wdata[13]))
    else $error("aux output b pin not inverse of written bit");
  aux_a_pin_a: assert property (
    ctl_write_s |=> o_aux_modem_output_a_pin_n == !$past(i_wdata[12]))
    else $error("aux output a pin not inverse of written bit");
  req_send_pin_a: assert property (
    ctl_write_s |=> o_request_send_pin_n == !$past(i_wdata[11]))
    else $error("request send pin not inverse of written bit");
  term_ready_pin_a: assert property (
    ctl_write_s |=> o_terminal_ready_pin_n == !$past(i_wdata[10]))
    else $error("terminal ready pin not inverse of written bit");
  modem_pins_hold_a: assert property (
    !ctl_wr |=> $stable(pins))
    else $error("modem pins moved without a control write");
  ctrl_readback_a: assert property (
    ctl_rd |=> o_rdata == $past(ctl_ff))
    else $error("control readback differs from written value");
  rdata_idle_a: assert property (
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  ir_serial_idle_a: assert property (
    ir_on_s |-> o_serial_transmit_pin)
    else $error("serial output not marking in infrared mode");
  ir_dark_a: assert property (
    ir_off_s |-> !o_infrared_output_n)
    else $error("infrared pulse while infrared mode off");
endmodule : ucm_port_ctl_assertions

bind ucm_port_ctl ucm_port_ctl_assertions u_chk (
  .i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_serial_transmit_pin,
  .o_infrared_output_n, .o_request_send_pin_n, .o_terminal_ready_pin_n,
  .o_aux_modem_output_a_pin_n, .o_aux_modem_output_b_pin_n
);

// ---- tb/ucm_peer_model.sv ----
module ucm_peer_model (
  input  wire logic        i_echo,
  input  wire logic        i_modem_act,
  input  wire logic        i_txd,
  output logic             o_rxd,
  output logic             o_ir_rx,
  output logic [3:0]       o_modem_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // echo plug, or a released line pulled up to marking
  assign o_rxd     = i_echo ? i_txd : 1'b1;
  // no light seen, receiver idles high
  assign o_ir_rx   = 1'b1;
  // the four status lines asserted or released together
  assign o_modem_n = {4{!i_modem_act}};
endmodule : ucm_peer_model

// ---- tb/test_uart_control_modem_loopback.sv ----
`include "ucm_cfg.svh"

module test_uart_control_modem_loopback;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] EN = 16'h0301; // port, transmit and receive on
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        echo = 1'b0;
  logic        act = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] st;
  logic [15:0] rd_v;
  logic [3:0]  mdm_n;
  logic [15:0] rd_q;
  logic        ir_seen = 1'b0;
  logic        rxd, irx, txd, iro, rts_n, dtr_n, aa_n, ab_n;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          smap [4] = '{9, 8, 10, 11};
  wire  [15:0] pins = {12'h000, ab_n, aa_n, rts_n, dtr_n};

  ucm_port_ctl u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_q),
    .i_serial_receive_pin(rxd), .o_serial_transmit_pin(txd), .i_infrared_input(irx),
    .o_infrared_output_n(iro), .i_clear_send_pin_n(mdm_n[0]), .i_set_ready_pin_n(mdm_n[1]),
    .i_carrier_pin_n(mdm_n[2]), .i_ring_pin_n(mdm_n[3]), .o_request_send_pin_n(rts_n),
    .o_terminal_ready_pin_n(dtr_n), .o_aux_modem_output_a_pin_n(aa_n),
    .o_aux_modem_output_b_pin_n(ab_n));
  ucm_peer_model u_peer (.i_echo(echo), .i_modem_act(act), .i_txd(txd), .o_rxd(rxd),
    .o_ir_rx(irx), .o_modem_n(mdm_n));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and run limit
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    // remembers any light pulse on the infrared output
    if (iro === 1'b1) begin
      ir_seen <= 1'b1;
    end
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = rd_q;
  endtask : rd
  // poll for a received character, then read and compare it
  task automatic wait_rx(input logic [7:0] exp);
    st = 16'h0000;
    for (int i = 0; i < 4000 && st[2] !== 1'b1; i++) rd(`UCM_STAT_OFF, st);
    chk("rx valid", {15'h0000, st[2]}, 16'h0001);
    rd(`UCM_DATA_OFF, rd_v);
    chk("rx byte", {8'h00, rd_v[7:0]}, {8'h00, exp});
  endtask : wait_rx
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk("pins after reset", pins, 16'h000f);
    rd(`UCM_CTRL_OFF, rd_v);
    chk("ctrl reset", rd_v, 16'h0300);
    // each modem bit alone, then the same bit looped back into status
    for (int b = 10; b < 14; b++) begin
      wr(`UCM_CTRL_OFF, EN | (16'h0001 << b));
      #1 chk("modem pins", pins, 16'h000f ^ (16'h0001 << (b - 10)));
      rd(`UCM_CTRL_OFF, rd_v);
      chk("ctrl readback", rd_v, EN | (16'h0001 << b));
      wr(`UCM_CTRL_OFF, EN | 16'h0080 | (16'h0001 << b));
      repeat (4) @(posedge i_mclk);
      rd(`UCM_STAT_OFF, st);
      chk("looped status", {12'h000, st[11:8]}, 16'h0001 << (smap[b - 10] - 8));
    end
    act = 1'b1;
    wr(`UCM_CTRL_OFF, EN | 16'h0002);
    repeat (4) @(posedge i_mclk);
    rd(`UCM_STAT_OFF, st);
    chk("ir modem status", {12'h000, st[11:8]}, 16'h0000);
    rd(8'h44, rd_v);
    chk("unmapped read", rd_v, 16'h0000);
    // held back by port enable, then by transmit enable
    echo = 1'b1;
    wr(`UCM_CTRL_OFF, 16'h0300);
    wr(`UCM_DATA_OFF, 16'h0096);
    repeat (700) @(posedge i_mclk);
    rd(`UCM_STAT_OFF, st);
    chk("no port enable", {14'h0000, st[1:0]}, 16'h0001);
    wr(`UCM_CTRL_OFF, 16'h0201);
    repeat (700) @(posedge i_mclk);
    rd(`UCM_STAT_OFF, st);
    chk("no tx enable", {14'h0000, st[1:0]}, 16'h0001);
    wr(`UCM_CTRL_OFF, EN);
    wait_rx(8'h96);
    // receiver off: the echoed character must not land
    wr(`UCM_CTRL_OFF, 16'h0101);
    wr(`UCM_DATA_OFF, 16'h003c);
    repeat (4000) @(posedge i_mclk);
    rd(`UCM_STAT_OFF, st);
    chk("rx disabled", {15'h0000, st[2]}, 16'h0000);
    // both sections disabled mid character
    wr(`UCM_CTRL_OFF, EN);
    wr(`UCM_DATA_OFF, 16'h0081);
    repeat (1000) @(posedge i_mclk);
    wr(`UCM_CTRL_OFF, 16'h0001);
    wait_rx(8'h81);
    // internal serial loopback with the line left marking
    echo = 1'b0;
    wr(`UCM_CTRL_OFF, EN | 16'h0080);
    wr(`UCM_DATA_OFF, 16'h00a5);
    wait_rx(8'ha5);
    chk("ir dark", {15'h0000, ir_seen}, 16'h0000);
    // infrared loopback under the test override
    wr(`UCM_TEST_OFF, 16'h0004);
    rd(`UCM_TEST_OFF, rd_v);
    chk("test readback", rd_v, 16'h0004);
    wr(`UCM_CTRL_OFF, EN | 16'h0082);
    wr(`UCM_DATA_OFF, 16'h005a);
    wait_rx(8'h5a);
    chk("ir pulse out", {15'h0000, ir_seen}, 16'h0001);
    wr(`UCM_TEST_OFF, 16'h0000);
    final_report();
  end
endmodule : test_uart_control_modem_loopback
